// File: verilog/ivc_map.svh
`ifndef IVC_MAP_SVH
`define IVC_MAP_SVH

// ----------------------------------------------------------------------------
// Source and vector geometry
// ----------------------------------------------------------------------------
`define IVC_NUM_SRC 151
`define IVC_NUM_TRAP 8
`define IVC_VEC_OFFSET 8'h08
`define IVC_TABLE_BASE 24'h000004
`define IVC_RESET_PC 24'h000000

// ----------------------------------------------------------------------------
// Register word indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define IVC_FLAG_IDX 10'h000
`define IVC_EN_IDX 10'h010
`define IVC_PRI_IDX 10'h020
`define IVC_NUM_GROUPS 10'h00A
`define IVC_NUM_PRI 10'h026
`define IVC_CPU_LVL_IDX 10'h080
`define IVC_STATUS_IDX 10'h081
`define IVC_TRAP_IDX 10'h082

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define IVC_STAT_LVL_LSB 8
`define IVC_PRI_FIELD_STEP 4
`define IVC_CPU_LVL_RST 4'h0
`define IVC_PRI_RST 3'h0

// ----------------------------------------------------------------------------
// Fixed entry and return latencies in clock cycles
// ----------------------------------------------------------------------------
`define IVC_ENTRY_CYC 4'hA
`define IVC_RETURN_CYC 4'h8

`endif

// File: verilog/ivc_pkg.sv
package ivc_pkg;

    // ------------------------------------------------------------------------
    // Bus request from the APB master.
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    // ------------------------------------------------------------------------
    // Interrupt request toward the core.
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic irq;
        logic [7:0] vec_num;
        logic [3:0] new_level;
        logic [23:0] vec_addr;
    } core_req_t;

    // ------------------------------------------------------------------------
    // Entry and return sequencer, Gray coded along idle-entry-service-return.
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ENTRY = 2'b01,
        ST_SERVICE = 2'b11,
        ST_RETURN = 2'b10
    } seq_state_t;

endpackage

// File: verilog/vectored_irq_ctrl.sv
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/100ps
`include "ivc_map.svh"

module vectored_irq_ctrl
    import ivc_pkg::*;
#(
    parameter bit P_HAS_CAN = 1'b1,
    parameter bit P_HAS_MOTOR = 1'b1
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire apb_req_t i_apb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [`IVC_NUM_SRC-1:0] i_req,
    input wire logic [`IVC_NUM_TRAP-1:0] i_trap,
    output core_req_t o_core,
    input wire logic i_ack,
    input wire logic i_ret,
    output logic o_entry_done,
    output logic o_return_done,
    output logic [23:0] o_reset_pc
);

    // ------------------------------------------------------------------------
    // Implemented request numbers
    // ------------------------------------------------------------------------

    // Returns one for request numbers that own a flag, enable and priority.
    function automatic bit src_impl(input int n, input bit can, input bit mc);
        bit base;
        bit var_can;
        bit var_mc;
        base = (n <= 14) || (n >= 16 && n <= 20) || (n >= 24 && n <= 33) ||
               (n >= 36 && n <= 38) || n == 49 || n == 50 || (n >= 65 && n <= 67) ||
               n == 77 || n == 142 || n == 143 || (n >= 145 && n <= 150);
        var_can = can && (n == 34 || n == 35 || n == 70);
        var_mc = mc && (n == 57 || n == 58 || (n >= 94 && n <= 96));
        return base || var_can || var_mc;
    endfunction

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic [`IVC_NUM_SRC-1:0] flag_q;
    logic [`IVC_NUM_SRC-1:0] en_q;
    logic [2:0] pri_q [0:`IVC_NUM_SRC-1];
    logic [`IVC_NUM_SRC-1:0] elig;
    logic [159:0] flag_flat;
    logic [159:0] en_flat;
    logic [607:0] pri_flat;
    logic [`IVC_NUM_TRAP-1:0] trap_q;
    logic [`IVC_NUM_TRAP-1:0] trap_d;
    logic [3:0] cpu_lvl_q;
    logic [3:0] cpu_lvl_d;
    logic [3:0] saved_lvl_q;
    logic [7:0] stat_vec_q;
    logic [3:0] stat_lvl_q;
    logic [31:0] prdata_q;
    seq_state_t state_q;
    seq_state_t state_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic irq_q;
    logic [7:0] vec_q;
    logic [3:0] lvl_q;
    logic entry_q;
    logic return_q;

    // ------------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------------
    wire [9:0] w_idx = i_apb.paddr[11:2];
    wire setup = i_apb.psel && !i_apb.penable;
    wire hit_flag = (w_idx >= `IVC_FLAG_IDX) && (w_idx < `IVC_FLAG_IDX + `IVC_NUM_GROUPS);
    wire hit_en = (w_idx >= `IVC_EN_IDX) && (w_idx < `IVC_EN_IDX + `IVC_NUM_GROUPS);
    wire hit_pri = (w_idx >= `IVC_PRI_IDX) && (w_idx < `IVC_PRI_IDX + `IVC_NUM_PRI);
    wire hit_cpu = (w_idx == `IVC_CPU_LVL_IDX);
    wire hit_stat = (w_idx == `IVC_STATUS_IDX);
    wire hit_trap = (w_idx == `IVC_TRAP_IDX);
    wire mapped = (i_apb.paddr[1:0] == 2'h0) && (hit_flag || hit_en || hit_pri || hit_cpu || hit_stat || hit_trap);
    wire wr_en = i_apb.psel && i_apb.penable && i_apb.pwrite && mapped;
    wire [3:0] g_idx = hit_flag ? 4'(w_idx - `IVC_FLAG_IDX) : 4'(w_idx - `IVC_EN_IDX);
    wire [5:0] k_idx = 6'(w_idx - `IVC_PRI_IDX);
    wire [15:0] wdata = i_apb.pwdata[15:0];

    // Zero-wait slave: every access completes in its first access cycle.
    assign o_pready = 1'b1;
    assign o_pslverr = i_apb.psel && i_apb.penable && !mapped;
    assign o_prdata = prdata_q;

    // ------------------------------------------------------------------------
    // Per-source flag, enable and priority storage
    // ------------------------------------------------------------------------
    genvar n;
    generate
        for (n = 0; n < `IVC_NUM_SRC; n++) begin : g_src
            localparam int G = n / 16;
            localparam int B = n % 16;
            localparam int K = n / 4;
            localparam int F = `IVC_PRI_FIELD_STEP * (n % 4);
            wire fl_wr = wr_en && hit_flag && (g_idx == 4'(G));
            wire en_wr = wr_en && hit_en && (g_idx == 4'(G));
            wire pr_wr = wr_en && hit_pri && (k_idx == 6'(K));
            if (src_impl(n, P_HAS_CAN, P_HAS_MOTOR)) begin : g_impl
                // The peripheral's set wins over a software clear in the same cycle.
                always_ff @(posedge i_mclk) begin
                    if (!i_rst_n) begin
                        flag_q[n] <= 1'b0;
                        en_q[n] <= 1'b0;
                        pri_q[n] <= `IVC_PRI_RST;
                    end else begin
                        flag_q[n] <= (fl_wr ? wdata[B] : flag_q[n]) | i_req[n];
                        en_q[n] <= en_wr ? wdata[B] : en_q[n];
                        pri_q[n] <= pr_wr ? wdata[F +: 3] : pri_q[n];
                    end
                end
            end else begin : g_rsvd
                // Reserved positions hold nothing and never request.
                assign flag_q[n] = 1'b0;
                assign en_q[n] = 1'b0;
                assign pri_q[n] = 3'h0;
            end
            // A source passes only when flagged, enabled and above the CPU level.
            assign elig[n] = flag_q[n] && en_q[n] && (pri_q[n] > cpu_lvl_q[2:0]) && !cpu_lvl_q[3];
            assign pri_flat[4*n +: 4] = {1'b0, pri_q[n]};
        end
    endgenerate

    // Flat read views padded with zeros above the last request number.
    assign flag_flat = {9'h000, flag_q};
    assign en_flat = {9'h000, en_q};
    assign pri_flat[607:604] = 4'h0;

    // ------------------------------------------------------------------------
    // Priority resolution
    // ------------------------------------------------------------------------
    logic best_found;
    logic [2:0] best_pri;
    logic [7:0] best_idx;
    logic trap_found;
    logic [2:0] trap_idx;

    // Scanning downward with >= lets the lower request take every tie.
    always_comb begin
        best_found = 1'b0;
        best_pri = 3'h0;
        best_idx = 8'h00;
        for (int i = `IVC_NUM_SRC - 1; i >= 0; i--) begin
            if (elig[i] && (!best_found || pri_q[i] >= best_pri)) begin
                best_found = 1'b1;
                best_pri = pri_q[i];
                best_idx = 8'(i);
            end
        end
    end

    // Traps take the lowest vectors, so the lowest pending trap always wins.
    always_comb begin
        trap_found = 1'b0;
        trap_idx = 3'h0;
        for (int t = `IVC_NUM_TRAP - 1; t >= 0; t--) begin
            if (trap_q[t]) begin
                trap_found = 1'b1;
                trap_idx = 3'(t);
            end
        end
    end

    wire win_any = trap_found || best_found;
    wire [7:0] win_vec = trap_found ? {5'h00, trap_idx} : best_idx + `IVC_VEC_OFFSET;
    wire [3:0] win_lvl = trap_found ? {1'b1, 3'h7 - trap_idx} : {1'b0, best_pri};

    // Winner registered toward the core each cycle.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            irq_q <= 1'b0;
            vec_q <= 8'h00;
            lvl_q <= 4'h0;
        end else begin
            irq_q <= win_any && (state_q == ST_IDLE);
            vec_q <= win_vec;
            lvl_q <= win_lvl;
        end
    end

    assign o_core.irq = irq_q;
    assign o_core.vec_num = vec_q;
    assign o_core.new_level = lvl_q;
    assign o_core.vec_addr = `IVC_TABLE_BASE + {15'h0000, vec_q, 1'b0};
    assign o_reset_pc = `IVC_RESET_PC;

    // ------------------------------------------------------------------------
    // Trap flags and CPU priority level
    // ------------------------------------------------------------------------
    wire take = (state_q == ST_IDLE) && irq_q && i_ack;
    wire ret_end = (state_q == ST_RETURN) && (cnt_q == 4'h1);

    // Trap flags: hardware set wins over a software clear.
    assign trap_d = ((wr_en && hit_trap) ? wdata[7:0] : trap_q) | i_trap;

    // Software writes only the low three bits; hardware alone moves the top bit.
    always_comb begin
        cpu_lvl_d = cpu_lvl_q;
        if (wr_en && hit_cpu) begin
            cpu_lvl_d = {cpu_lvl_q[3], wdata[2:0]};
        end
        if (take) begin
            cpu_lvl_d = lvl_q;
        end else if (ret_end) begin
            cpu_lvl_d = saved_lvl_q;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            trap_q <= '0;
            cpu_lvl_q <= `IVC_CPU_LVL_RST;
            saved_lvl_q <= `IVC_CPU_LVL_RST;
            stat_vec_q <= 8'h00;
            stat_lvl_q <= 4'h0;
        end else begin
            trap_q <= trap_d;
            cpu_lvl_q <= cpu_lvl_d;
            if (take) begin
                saved_lvl_q <= cpu_lvl_q;
                stat_vec_q <= vec_q;
                stat_lvl_q <= lvl_q;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Entry and return sequencer
    // ------------------------------------------------------------------------

    // Every entry and return takes the same count whatever the source.
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            ST_IDLE: begin
                if (take) begin
                    state_d = ST_ENTRY;
                    cnt_d = `IVC_ENTRY_CYC;
                end
            end
            ST_ENTRY: begin
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h1) begin
                    state_d = ST_SERVICE;
                end
            end
            ST_SERVICE: begin
                if (i_ret) begin
                    state_d = ST_RETURN;
                    cnt_d = `IVC_RETURN_CYC;
                end
            end
            ST_RETURN: begin
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h1) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
                cnt_d = 4'h0;
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
            entry_q <= 1'b0;
            return_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            entry_q <= (state_q == ST_ENTRY) && (cnt_q == 4'h1);
            return_q <= ret_end;
        end
    end

    assign o_entry_done = entry_q;
    assign o_return_done = return_q;

    // ------------------------------------------------------------------------
    // Read data, captured in the setup cycle
    // ------------------------------------------------------------------------
    logic [31:0] rd_word;

    always_comb begin
        rd_word = 32'h00000000;
        if (hit_flag) begin
            rd_word = {16'h0000, flag_flat[16*g_idx +: 16]};
        end else if (hit_en) begin
            rd_word = {16'h0000, en_flat[16*g_idx +: 16]};
        end else if (hit_pri) begin
            rd_word = {16'h0000, pri_flat[16*k_idx +: 16]};
        end else if (hit_cpu) begin
            rd_word = {28'h0000000, cpu_lvl_q};
        end else if (hit_stat) begin
            rd_word = {20'h00000, stat_lvl_q, stat_vec_q};
        end else if (hit_trap) begin
            rd_word = {24'h000000, trap_q};
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            prdata_q <= 32'h00000000;
        end else if (setup) begin
            prdata_q <= mapped ? rd_word : 32'h00000000;
        end
    end

endmodule

// File: bench/ivc_assertions.sv
`timescale 1ns/100ps
`include "ivc_map.svh"

module ivc_checker
    import ivc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire apb_req_t i_apb,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic [`IVC_NUM_SRC-1:0] i_req,
    input wire logic [`IVC_NUM_TRAP-1:0] i_trap,
    input wire core_req_t o_core,
    input wire logic i_ack,
    input wire logic i_ret,
    input wire logic o_entry_done,
    input wire logic o_return_done,
    input wire logic [23:0] o_reset_pc
);
    logic svc_q;
    logic svc_d;

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);

    // Marks the span from entry done until return done.
    assign svc_d = o_return_done ? 1'b0 : (o_entry_done | svc_q);
    always_ff @(posedge i_mclk) begin
        svc_q <= i_rst_n ? svc_d : 1'b0;
    end

    // ------------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------------
    reset_pc_zero_a: assert property (o_reset_pc == 24'h000000)
        else $error("reset address not zero");
    slot_addr_a: assert property (o_core.irq |->
        o_core.vec_addr == 24'h000004 + {15'h0000, o_core.vec_num, 1'b0})
        else $error("vector slot address wrong");
    vec_range_a: assert property (o_core.irq |-> (o_core.new_level[3] ?
        o_core.vec_num == 8'h0F - {4'h0, o_core.new_level} : (o_core.vec_num >= 8'h08 && o_core.vec_num <= 8'h9E)))
        else $error("vector number out of range");
    level_above_a: assert property (o_core.irq |-> o_core.new_level != 4'h0)
        else $error("request at level zero");
    entry_latency_a: assert property (o_core.irq && i_ack |-> ##11 o_entry_done)
        else $error("entry latency wrong");
    entry_pulse_a: assert property (o_entry_done |=> !o_entry_done)
        else $error("entry done longer than one cycle");
    return_latency_a: assert property (svc_q && i_ret |-> ##9 o_return_done)
        else $error("return latency wrong");
    single_req_a: assert property (o_core.irq && i_ack |=> ##1 !o_core.irq [*8])
        else $error("request raised during entry");
    err_phase_a: assert property (o_pslverr |-> i_apb.psel && i_apb.penable)
        else $error("error outside access phase");
    err_data_a: assert property (o_pslverr && !i_apb.pwrite |-> o_prdata == 32'h00000000)
        else $error("unmapped read not zero");
endmodule

bind vectored_irq_ctrl ivc_checker ivc_checker_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_apb(i_apb),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_req(i_req), .i_trap(i_trap),
    .o_core(o_core), .i_ack(i_ack), .i_ret(i_ret), .o_entry_done(o_entry_done),
    .o_return_done(o_return_done), .o_reset_pc(o_reset_pc));

// File: bench/core_model.sv
`timescale 1ns/100ps

module core_model
    import ivc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire core_req_t i_core,
    input wire logic i_entry_done,
    input wire logic i_return_done,
    input wire logic i_slow,
    output logic o_ack,
    output logic o_ret,
    output logic [7:0] o_vec,
    output logic [3:0] o_lvl,
    output logic [15:0] o_cnt
);
    int k;

    // Takes a request, waits out entry, services a while, then returns.
    initial begin
        o_ack = 1'b0;
        o_ret = 1'b0;
        o_vec = 8'h00;
        o_lvl = 4'h0;
        o_cnt = 16'h0000;
        forever begin
            @(posedge i_mclk);
            if (i_rst_n && i_core.irq === 1'b1) begin
                repeat (i_slow ? 4 : 0) @(posedge i_mclk);
                o_ack <= 1'b1;
                @(posedge i_mclk);
                o_ack <= 1'b0;
                if (i_core.irq === 1'b1) begin
                    // Records the taken vector number and new level, and counts the request.
                    o_vec <= i_core.vec_num;
                    o_lvl <= i_core.new_level;
                    o_cnt <= o_cnt + 16'h0001;
                    k = 0;
                    while (i_entry_done !== 1'b1 && k < 20) begin
                        @(posedge i_mclk);
                        k++;
                    end
                    repeat (20) @(posedge i_mclk);
                    o_ret <= 1'b1;
                    @(posedge i_mclk);
                    o_ret <= 1'b0;
                    // No new request is taken before the return sequence has ended.
                    k = 0;
                    while (i_return_done !== 1'b1 && k < 20) begin
                        @(posedge i_mclk);
                        k++;
                    end
                end
            end
        end
    end
endmodule

// File: bench/vectored_irq_ctrl_tb.sv
`timescale 1ns/100ps
`include "ivc_map.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, e); end end

module vectored_irq_ctrl_tb
    import ivc_pkg::*;
;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    apb_req_t apb = '0;
    logic [`IVC_NUM_SRC-1:0] req = '0;
    logic [`IVC_NUM_SRC-1:0] rq;
    logic [7:0] trap = 8'h00;
    logic [7:0] tr;
    logic slow = 1'b0;
    logic [31:0] prdata, r, m;
    logic pready, pslverr, sp, ack, ret, entry_done, return_done;
    core_req_t core;
    logic [23:0] reset_pc;
    logic [7:0] mvec;
    logic [3:0] mlvl;
    logic [15:0] mcnt, cnt0;
    logic [31:0] en_sh[10];
    logic [31:0] pr_sh[38];
    int errors = 0;
    int checks = 0;
    int n[3], p[3], e[3];
    int lv, ev, el, k;

    vectored_irq_ctrl #(.P_HAS_CAN(1'b0), .P_HAS_MOTOR(1'b1)) vectored_irq_ctrl_i (.i_mclk(i_mclk),
        .i_rst_n(i_rst_n), .i_apb(apb), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_req(req), .i_trap(trap), .o_core(core), .i_ack(ack), .i_ret(ret), .o_entry_done(entry_done),
        .o_return_done(return_done), .o_reset_pc(reset_pc));
    core_model core_model_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_core(core), .i_entry_done(entry_done),
        .i_return_done(return_done), .i_slow(slow), .o_ack(ack), .o_ret(ret), .o_vec(mvec), .o_lvl(mlvl),
        .o_cnt(mcnt));

    // Free-running 100 MHz clock.
    always #5 i_mclk = ~i_mclk;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    task automatic finish_test();
        if (errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // One APB transfer, then an idle cycle so the next setup never collides.
    task automatic bus(input logic w, input logic [9:0] idx, input logic [31:0] d);
        int c;
        apb <= '{1'b1, 1'b0, w, {idx, 2'b00}, d};
        @(posedge i_mclk);
        apb.penable <= 1'b1;
        c = 0;
        do begin
            @(posedge i_mclk);
            c++;
        end while (pready !== 1'b1 && c < 20);
        r = prdata;
        sp = pslverr;
        if (pready !== 1'b1) begin
            errors++;
            finish_test();
        end
        apb <= '0;
        @(posedge i_mclk);
    endtask

    // Request numbers with storage when the CAN events are absent.
    function automatic bit impl(input int q);
        return !(q == 15 || (q >= 21 && q <= 23) || (q >= 39 && q <= 48) || (q >= 51 && q <= 56) ||
            (q >= 59 && q <= 64) || q == 68 || q == 69 || (q >= 71 && q <= 76) || (q >= 78 && q <= 93) ||
            (q >= 97 && q <= 141) || q == 144 || q == 34 || q == 35 || q == 70 || q > 150);
    endfunction

    // Winner: lowest trap index first, else highest level with the lowest number.
    function automatic void predict(input logic [7:0] t);
        ev = -1;
        el = 0;
        for (int i = 7; i >= 0; i--) begin
            if (t[i]) begin
                ev = i;
                el = 15 - i;
            end
        end
        for (int i = 0; i < 3; i++) begin
            if (ev < 8 && ev >= 0) break;
            if (e[i] != 0 && p[i] > lv && (p[i] > el || (p[i] == el && n[i] + 8 < ev))) begin
                ev = n[i] + 8;
                el = p[i];
            end
        end
    endfunction

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        void'($urandom(32'hA6A9926E));
        repeat (4) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        @(posedge i_mclk);
        bus(1'b1, `IVC_CPU_LVL_IDX, 32'hFFFFFFFF);
        bus(1'b0, `IVC_CPU_LVL_IDX, 32'h0);
        `CHK(r, 32'h00000007)
        bus(1'b0, 10'h3FF, 32'h0);
        `CHK({sp, r}, {1'b1, 32'h0})
        for (int g = 0; g < 10; g++) begin
            for (int b = 0; b < 16; b++) m[b] = impl(16 * g + b);
            m[31:16] = 16'h0000;
            bus(1'b1, `IVC_FLAG_IDX + 10'(g), 32'hFFFFFFFF);
            bus(1'b0, `IVC_FLAG_IDX + 10'(g), 32'h0);
            `CHK(r, m)
            bus(1'b1, `IVC_EN_IDX + 10'(g), 32'hFFFFFFFF);
            bus(1'b0, `IVC_EN_IDX + 10'(g), 32'h0);
            `CHK(r, m)
            bus(1'b1, `IVC_FLAG_IDX + 10'(g), 32'h0);
            bus(1'b1, `IVC_EN_IDX + 10'(g), 32'h0);
            en_sh[g] = 32'h0;
        end
        for (int q = 0; q < 38; q++) begin
            m = 32'h0;
            for (int j = 0; j < 4; j++) if (impl(4 * q + j)) m[4 * j +: 3] = 3'h7;
            bus(1'b1, `IVC_PRI_IDX + 10'(q), 32'hFFFFFFFF);
            bus(1'b0, `IVC_PRI_IDX + 10'(q), 32'h0);
            `CHK(r, m)
            bus(1'b1, `IVC_PRI_IDX + 10'(q), 32'h0);
            pr_sh[q] = 32'h0;
        end
        // Random rounds; the first two are a win by the top source at level 7 and a round with every source at or below the CPU level.
        for (int it = 0; it < 40; it++) begin
            lv = $urandom_range(7);
            slow <= 1'($urandom_range(1));
            for (int i = 0; i < 3; i++) begin
                do n[i] = 50 * i + $urandom_range(49); while (!impl(n[i]));
                p[i] = $urandom_range(7, 1);
                e[i] = ($urandom_range(3) != 0);
            end
            tr = ($urandom_range(3) == 0) ? 8'($urandom) : 8'h00;
            if (it < 2) begin
                n = '{0, 57, 150};
                p = '{5, 5, (it == 0) ? 7 : 3};
                e = '{1, 1, 1};
                lv = 4 + it;
                tr = 8'h00;
            end
            bus(1'b1, `IVC_CPU_LVL_IDX, 32'(lv));
            rq = '0;
            for (int i = 0; i < 3; i++) begin
                en_sh[n[i] / 16][n[i] % 16] = e[i][0];
                pr_sh[n[i] / 4][4 * (n[i] % 4) +: 3] = 3'(p[i]);
                bus(1'b1, `IVC_EN_IDX + 10'(n[i] / 16), en_sh[n[i] / 16]);
                bus(1'b1, `IVC_PRI_IDX + 10'(n[i] / 4), pr_sh[n[i] / 4]);
                rq[n[i]] = 1'b1;
            end
            predict(tr);
            cnt0 = mcnt;
            req <= rq;
            trap <= tr;
            @(posedge i_mclk);
            req <= '0;
            trap <= 8'h00;
            k = 0;
            while (mcnt === cnt0 && k < 60) begin
                @(posedge i_mclk);
                k++;
            end
            if (ev < 0) begin
                `CHK(mcnt, cnt0)
            end else begin
                `CHK(mcnt, cnt0 + 16'h0001)
                if (mcnt === cnt0) finish_test();
                `CHK({mlvl, mvec}, {4'(el), 8'(ev)})
                bus(1'b0, `IVC_STATUS_IDX, 32'h0);
                `CHK(r, {20'h00000, 4'(el), 8'(ev)})
                bus(1'b0, `IVC_CPU_LVL_IDX, 32'h0);
                `CHK(r, 32'(el))
            end
            for (int i = 0; i < 3; i++) bus(1'b1, `IVC_FLAG_IDX + 10'(n[i] / 16), 32'h0);
            bus(1'b1, `IVC_TRAP_IDX, 32'h0);
            if (ev >= 0) begin
                k = 0;
                while (return_done !== 1'b1 && k < 80) begin
                    @(posedge i_mclk);
                    k++;
                end
                `CHK(return_done, 1'b1)
                if (return_done !== 1'b1) finish_test();
                @(posedge i_mclk);
                bus(1'b0, `IVC_CPU_LVL_IDX, 32'h0);
                `CHK(r, 32'(lv))
            end
        end
        // Reset in mid-run clears what software wrote.
        bus(1'b1, `IVC_CPU_LVL_IDX, 32'h7);
        bus(1'b1, `IVC_FLAG_IDX, 32'h0000FFFF);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        @(posedge i_mclk);
        bus(1'b0, `IVC_FLAG_IDX, 32'h0);
        `CHK(r, 32'h0)
        bus(1'b0, `IVC_CPU_LVL_IDX, 32'h0);
        `CHK(r, 32'h0)
        `CHK(reset_pc, 24'h000000)
        finish_test();
    end
endmodule
